// *** rtl/rap_pkg.sv ***
// shared constants and carriers for the register access policy block
package rap_pkg;

    // ------------------------------------------------------------
    // address map
    // ------------------------------------------------------------
    localparam logic [7:0] RAP_USER_LO = 8'h00;
    localparam logic [7:0] RAP_USER_HI = 8'h98;
    localparam logic [7:0] RAP_RSV_A = 8'h5d;
    localparam logic [7:0] RAP_RSV_B = 8'h5e;
    localparam int RAP_NREG = 153;
    localparam logic [7:0] RAP_VERSION_ADDR = 8'h00;
    localparam logic [7:0] RAP_STAT1_ADDR = 8'h02;
    localparam logic [7:0] RAP_STAT2_ADDR = 8'h03;
    localparam logic [7:0] RAP_STAT3_ADDR = 8'h04;
    localparam logic [7:0] RAP_DEVCFG1_ADDR = 8'h14;
    localparam logic [7:0] RAP_DEVCFG2_ADDR = 8'h15;
    localparam logic [7:0] RAP_THR_LO = 8'h1f;
    localparam logic [7:0] RAP_THR_HI = 8'h30;

    // ------------------------------------------------------------
    // lock groups: each internal process locks one address group
    // ------------------------------------------------------------
    localparam logic [7:0] RAP_GRP1_LO = 8'h14;
    localparam logic [7:0] RAP_GRP2_LO = 8'h19;
    localparam logic [7:0] RAP_GRP3_LO = 8'h1f;
    localparam int RAP_NGRP = 4;

    // ------------------------------------------------------------
    // field positions and values
    // ------------------------------------------------------------
    localparam int RAP_S1_PEC_BIT = 5;
    localparam int RAP_S1_INTRFC_BIT = 4;
    localparam int RAP_S2_SPI_BIT = 7;
    localparam int RAP_S2_RJCT_BIT = 0;
    localparam int RAP_SPARE_A_BIT = 8;
    localparam int RAP_SPARE_B_LSB = 8;
    // model code value is arbitrary
    localparam logic [15:0] RAP_VERSION_RST = 16'h0a51;
    localparam logic [15:0] RAP_ZERO = 16'h0000;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
        logic [15:0] wdata;
        logic pec_err;
        logic frame_err;
        logic spi_err;
    } rap_req_t;

    typedef struct packed {
        logic valid;
        logic ok;
        logic busy_rej;
        logic [15:0] rdata;
    } rap_rsp_t;

endpackage

// *** rtl/rap_register_access_policy.sv ***
// register map with reserved-address, bitfield and busy-lock access policy
//
// Overview of operation
// - accept transactions only without protocol errors; flag errors in status words one and two
// - a protocol-error transaction is rejected whole; no reserved handling applies
// - user registers decode in 0x00..0x98; addresses there without their own mask, other than 0x00, 0x02, 0x03, 0x5d and 0x5e, store all sixteen bits
// - addresses 0x5d and 0x5e are reserved
// - addresses 0x99 through 0xff are reserved
// - valid read of a reserved address completes with no error; a valid write there gets no answer
// - writes to reserved addresses are dropped; reads return zero
// - block read-back returns zero for reserved addresses and skips none
// - integrity checks cover all sixteen data bits including unused ones
// - unused bits are never stored and always read zero
// - one-bit and four-bit spare fields store, read back, affect nothing
// - valid write to a busy-locked register is ignored and sets the reject flag
`timescale 1ns/1ps
module rap_register_access_policy
    import rap_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // transaction from the link layer, checks already evaluated
    input wire rap_req_t req_i,
    // lock per address group from internal processes
    input wire logic [RAP_NGRP-1:0] grp_busy_i,
    // transaction answer
    output rap_rsp_t rsp_o,
    // status view
    output logic [15:0] first_status_word_o,
    output logic [15:0] second_status_word_o,
    output logic write_rejected_flag_o,
    // spare configuration fields, no internal effect
    output logic spare_cfg_bit_a_o,
    output logic [3:0] spare_cfg_nibble_b_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [RAP_NREG-1:0][15:0] regs;
        rap_rsp_t rsp;
    } rap_state_t;

    // transaction classes, judged before any register is touched
    typedef enum logic [2:0] {
        KIND_IDLE,
        KIND_ERROR,
        KIND_READ,
        KIND_RSV_WRITE,
        KIND_BUSY_WRITE,
        KIND_WRITE
    } rap_kind_t;

    rap_state_t st;
    rap_state_t next_st;
    logic rst_meta;
    logic rst_sync;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic is_reserved(input logic [7:0] a);
        is_reserved = (a > RAP_USER_HI)
            || (a == RAP_RSV_A) || (a == RAP_RSV_B);
    endfunction

    // implemented bits of each register; unused positions are zero
    function automatic logic [15:0] used_mask(input logic [7:0] a);
        if (a == RAP_STAT3_ADDR) begin
            used_mask = 16'hf800;
        end else if (a == 8'h0a) begin
            used_mask = 16'h0f0f;
        end else if ((a >= 8'h0b && a <= 8'h0d) || a == 8'h10 || a == 8'h11) begin
            used_mask = 16'h000f;
        end else if (a == 8'h12) begin
            used_mask = 16'h3fff;
        end else if (a == 8'h13) begin
            used_mask = 16'h0001;
        end else if (a == RAP_DEVCFG2_ADDR) begin
            used_mask = 16'hefff;
        end else if (a >= RAP_THR_LO && a <= RAP_THR_HI) begin
            used_mask = 16'hfffc;
        end else begin
            used_mask = 16'hffff;
        end
    endfunction

    function automatic logic [1:0] grp_of(input logic [7:0] a);
        if (a >= RAP_GRP3_LO) begin
            grp_of = 2'h3;
        end else if (a >= RAP_GRP2_LO) begin
            grp_of = 2'h2;
        end else if (a >= RAP_GRP1_LO) begin
            grp_of = 2'h1;
        end else begin
            grp_of = 2'h0;
        end
    endfunction

    // protocol errors are judged first, so reserved handling never sees them
    function automatic rap_kind_t classify(input rap_req_t r, input logic [RAP_NGRP-1:0] bsy);
        if (!r.valid) begin
            classify = KIND_IDLE;
        end else if (r.pec_err || r.frame_err || r.spi_err) begin
            classify = KIND_ERROR;
        end else if (!r.write) begin
            classify = KIND_READ;
        end else if (is_reserved(r.addr)) begin
            classify = KIND_RSV_WRITE;
        end else if (bsy[grp_of(r.addr)]) begin
            classify = KIND_BUSY_WRITE;
        end else begin
            classify = KIND_WRITE;
        end
    endfunction

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    // assert at once, release after two edges so no flop sees a partial release
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        rap_kind_t kind;
        logic rsv;
        logic [7:0] a;
        logic [15:0] m;
        logic [15:0] clr1;
        logic [15:0] clr2;
        logic [15:0] set1;
        logic [15:0] set2;
        kind = classify(req_i, grp_busy_i);
        a = req_i.addr;
        rsv = is_reserved(a);
        m = used_mask(a);
        clr1 = RAP_ZERO;
        clr2 = RAP_ZERO;
        set1 = RAP_ZERO;
        set2 = RAP_ZERO;
        next_st = st;
        next_st.rsp = '0;
        case (kind)
            KIND_ERROR: begin
                // rejected before any address handling; only the alert bits change
                next_st.rsp.valid = 1'b1;
                set1[RAP_S1_PEC_BIT] = req_i.pec_err;
                set1[RAP_S1_INTRFC_BIT] = req_i.frame_err;
                set2[RAP_S2_SPI_BIT] = req_i.spi_err;
            end
            KIND_READ: begin
                next_st.rsp.valid = 1'b1;
                next_st.rsp.ok = 1'b1;
                // each address answers in turn, so block reads never skip
                next_st.rsp.rdata = rsv ? RAP_ZERO : (st.regs[a] & m);
            end
            KIND_RSV_WRITE: begin
                // dropped silently; the host sees no answer
                next_st.rsp.valid = 1'b0;
            end
            KIND_BUSY_WRITE: begin
                // the owning process keeps its operands; only the alert records the try
                next_st.rsp.valid = 1'b1;
                next_st.rsp.busy_rej = 1'b1;
                set2[RAP_S2_RJCT_BIT] = 1'b1;
            end
            KIND_WRITE: begin
                next_st.rsp.valid = 1'b1;
                next_st.rsp.ok = 1'b1;
                if (a == RAP_STAT1_ADDR) begin
                    clr1 = req_i.wdata;
                end else if (a == RAP_STAT2_ADDR) begin
                    clr2 = req_i.wdata;
                end else if (a != RAP_VERSION_ADDR) begin
                    // spare fields sit inside the mask and are stored as written
                    next_st.regs[a] = req_i.wdata & m;
                end
            end
            default: begin
                // no request this cycle: registers hold, no answer
                next_st.rsp = '0;
            end
        endcase
        // alert bits clear by writing one; a new event wins over the clear
        next_st.regs[RAP_STAT1_ADDR] = (st.regs[RAP_STAT1_ADDR] & ~clr1) | set1;
        next_st.regs[RAP_STAT2_ADDR] = (st.regs[RAP_STAT2_ADDR] & ~clr2) | set2;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_sync) begin
        if (!rst_sync) begin
            st <= '0;
            st.regs[RAP_VERSION_ADDR] <= RAP_VERSION_RST;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from the state flops
    // ------------------------------------------------------------
    always_comb begin
        rsp_o = st.rsp;
        first_status_word_o = st.regs[RAP_STAT1_ADDR];
        second_status_word_o = st.regs[RAP_STAT2_ADDR];
        write_rejected_flag_o = st.regs[RAP_STAT2_ADDR][RAP_S2_RJCT_BIT];
        spare_cfg_bit_a_o = st.regs[RAP_DEVCFG1_ADDR][RAP_SPARE_A_BIT];
        spare_cfg_nibble_b_o = st.regs[RAP_DEVCFG2_ADDR][RAP_SPARE_B_LSB +: 4];
    end

endmodule

// *** verification/rap_register_access_policy_assertions.sv ***
// concurrent checks on the register access policy block ports
`timescale 1ns/1ps
module rap_register_access_policy_checker
    import rap_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // request side
    input wire rap_req_t req_i,
    input wire logic [RAP_NGRP-1:0] grp_busy_i,
    // answer and status side
    input wire rap_rsp_t rsp_o,
    input wire logic [15:0] first_status_word_o,
    input wire logic [15:0] second_status_word_o,
    input wire logic write_rejected_flag_o,
    input wire logic spare_cfg_bit_a_o,
    input wire logic [3:0] spare_cfg_nibble_b_o
);
    logic err;
    logic rsv;
    logic bsy;
    assign err = req_i.pec_err | req_i.frame_err | req_i.spi_err;
    assign rsv = req_i.addr == RAP_RSV_A || req_i.addr == RAP_RSV_B || req_i.addr > RAP_USER_HI;
    assign bsy = req_i.addr < RAP_GRP1_LO ? grp_busy_i[0] : req_i.addr < RAP_GRP2_LO ?
                 grp_busy_i[1] : req_i.addr < RAP_GRP3_LO ? grp_busy_i[2] : grp_busy_i[3];
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    rsp_follow_a: assert property (
        req_i.valid && !(req_i.write && rsv && !err) |=> rsp_o.valid)
        else $error("no answer one cycle after request");
    err_reject_a: assert property (req_i.valid && err |=> !rsp_o.ok && !rsp_o.busy_rej)
        else $error("errored request not refused");
    rsvd_silent_a: assert property (
        req_i.valid && req_i.write && rsv && !err |=> !rsp_o.valid)
        else $error("reserved write answered");
    rsvd_zero_a: assert property (
        req_i.valid && !req_i.write && rsv && !err |=> rsp_o.ok && rsp_o.rdata == RAP_ZERO)
        else $error("reserved read not zero");
    busy_reject_a: assert property (
        req_i.valid && req_i.write && !rsv && !err && bsy
        |=> rsp_o.busy_rej && !rsp_o.ok && write_rejected_flag_o)
        else $error("busy write not rejected");
    pec_alert_a: assert property (
        req_i.valid && req_i.pec_err |=> first_status_word_o[RAP_S1_PEC_BIT])
        else $error("integrity alert missing");
    spi_alert_a: assert property (
        req_i.valid && req_i.spi_err |=> second_status_word_o[RAP_S2_SPI_BIT])
        else $error("serial alert missing");
    flag_mirror_a: assert property (
        write_rejected_flag_o && !(req_i.valid && req_i.write && req_i.addr == RAP_STAT2_ADDR)
        |=> write_rejected_flag_o && second_status_word_o[RAP_S2_RJCT_BIT])
        else $error("reject flag lost before clear");
    idle_quiet_a: assert property (!req_i.valid |=> !rsp_o.valid)
        else $error("answer without request");
    spare_hold_a: assert property (
        !(req_i.valid && req_i.write)
        |=> $stable(spare_cfg_nibble_b_o) && $stable(spare_cfg_bit_a_o))
        else $error("spare field changed without write");
endmodule

bind rap_register_access_policy rap_register_access_policy_checker i_chk (.clk_i(clk_i),
    .nrst_i(nrst_i), .req_i(req_i), .grp_busy_i(grp_busy_i), .rsp_o(rsp_o),
    .first_status_word_o(first_status_word_o), .second_status_word_o(second_status_word_o),
    .write_rejected_flag_o(write_rejected_flag_o), .spare_cfg_bit_a_o(spare_cfg_bit_a_o),
    .spare_cfg_nibble_b_o(spare_cfg_nibble_b_o));

// *** verification/rap_host_model.sv ***
// host controller model issuing single transfers to the policy block
`timescale 1ns/1ps
module rap_host_model
    import rap_pkg::*;
(
    input wire logic clk_i,
    output rap_req_t req_o
);
    initial req_o = '0;
    // reserved or busy writes come only when the bench asks for them
    task automatic send(input logic w, input logic [7:0] a, input logic [15:0] d,
                        input logic [2:0] e);
        @(negedge clk_i);
        req_o = '{1'b1, w, a, d, e[2], e[1], e[0]};
        @(negedge clk_i);
        // released command, address and data show the inverse so a stale value is never trusted
        req_o = '{1'b0, ~w, ~a, ~d, 1'b0, 1'b0, 1'b0};
    endtask
endmodule

// *** verification/tb_rap_register_access_policy.sv ***
// self-checking bench for the register access policy block
`timescale 1ns/1ps
module tb_rap_register_access_policy;
    import rap_pkg::*;
    typedef struct packed {
        logic w;
        logic [7:0] a;
        logic [15:0] d;
        logic [2:0] e;
        logic [3:0] b;
        logic [2:0] x;
        logic [15:0] r;
    } rap_row_t;
    // e is pec, frame, serial error; x is valid, ok, busy reject
    rap_row_t rows [20] = '{
        '{1, 8'h20, 16'hffff, 0, 0, 6, 0}, '{0, 8'h20, 0, 0, 0, 6, 16'hfffc},
        '{1, 8'h15, 16'hffff, 0, 0, 6, 0}, '{0, 8'h15, 0, 0, 0, 6, 16'hefff},
        '{1, 8'h14, 16'h0100, 0, 0, 6, 0}, '{1, 8'h98, 16'ha5a5, 0, 0, 6, 0},
        '{0, 8'h98, 0, 0, 0, 6, 16'ha5a5}, '{1, 8'h5d, 16'h1234, 0, 0, 0, 0},
        '{0, 8'h5d, 0, 0, 0, 6, 0}, '{0, 8'hff, 0, 0, 0, 6, 0},
        '{1, 8'h20, 0, 4, 0, 4, 0}, '{1, 8'h5e, 0, 2, 0, 4, 0},
        '{0, 8'h20, 0, 1, 0, 4, 0}, '{0, 8'h20, 0, 0, 0, 6, 16'hfffc},
        '{1, 8'h1f, 16'h0003, 0, 0, 6, 0}, '{1, 8'h1f, 16'hffff, 0, 8, 5, 0},
        '{0, 8'h1f, 0, 0, 8, 6, 0}, '{1, 8'h00, 16'hffff, 0, 0, 6, 0},
        '{0, 8'h00, 0, 0, 0, 6, RAP_VERSION_RST}, '{1, 8'h99, 0, 0, 8, 0, 0}};
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [3:0] grp_busy_i = '0;
    rap_req_t req;
    rap_rsp_t rsp;
    logic [15:0] s1;
    logic [15:0] s2;
    logic flag;
    logic spa;
    logic [3:0] spb;
    int checks = 0;
    int mismatches = 0;
    int cycles = 0;
    always #2 clk_i = ~clk_i;
    rap_host_model i_rap_host_model (.clk_i(clk_i), .req_o(req));
    rap_register_access_policy i_rap_register_access_policy (.clk_i(clk_i), .nrst_i(nrst_i),
        .req_i(req), .grp_busy_i(grp_busy_i), .rsp_o(rsp), .first_status_word_o(s1),
        .second_status_word_o(s2), .write_rejected_flag_o(flag), .spare_cfg_bit_a_o(spa),
        .spare_cfg_nibble_b_o(spb));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            report_and_stop();
        end
    end
    initial begin
        repeat (5) @(negedge clk_i);
        nrst_i = 1'b1;
        repeat (4) @(negedge clk_i);
        for (int i = 0; i < 20; i++) begin
            grp_busy_i = rows[i].b;
            i_rap_host_model.send(rows[i].w, rows[i].a, rows[i].d, rows[i].e);
            check(16'({rsp.valid, rsp.ok, rsp.busy_rej}), 16'(rows[i].x));
            if (!rows[i].w) begin
                check(rsp.rdata, rows[i].r);
            end
        end
        check(16'({s1[5:4], s2[7], flag, spa, spb}), 16'h01ff);
        i_rap_host_model.send(1'b1, RAP_STAT2_ADDR, 16'hffff, 3'h0);
        check(16'({s2[7], flag}), 16'h0000);
        // mid-run reset must clear both status words, the flag, the spare fields and answer valid at once
        nrst_i = 1'b0;
        @(negedge clk_i);
        check(s1 | s2 | 16'({rsp.valid, flag, spa, spb}), RAP_ZERO);
        report_and_stop();
    end
endmodule
